/* rtc_chk_pkg.sv */
// shared constants for the write check and supply-low detector
package rtc_chk_pkg;
  // bcd limits
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [7:0] YEAR_DEF    = 8'h00;
  localparam logic [7:0] MONTH_DEF   = 8'h01;
  localparam logic [7:0] MONTH_MAX   = 8'h12;
  localparam logic [2:0] DOW_DEF     = 3'h1;
  localparam logic [2:0] DOW_ZERO    = 3'h0;
  localparam logic [7:0] DATE_DEF    = 8'h01;
  localparam logic [7:0] DATE_MAX    = 8'h31;
  localparam logic [7:0] DATE_ZERO   = 8'h00;
  localparam logic [7:0] HOUR_DEF    = 8'h00;
  localparam logic [7:0] HOUR24_MAX  = 8'h23;
  localparam logic [7:0] HOUR12_MAX  = 8'h11;
  localparam logic [7:0] MIN_DEF     = 8'h00;
  localparam logic [7:0] MIN_MAX     = 8'h59;
  localparam logic [7:0] SEC_DEF     = 8'h00;
  localparam logic [7:0] SEC_MAX     = 8'h59;
  localparam logic [7:0] MONTH_FEB   = 8'h02;
  localparam logic [7:0] MONTH_DEC   = 8'h12;
  localparam logic [7:0] DAYS_28     = 8'h28;
  localparam logic [7:0] DAYS_29     = 8'h29;
  localparam logic [7:0] DAYS_30     = 8'h30;
  localparam logic [7:0] DAYS_31     = 8'h31;
  // hour and seconds field layout
  localparam int HOUR_MER_BIT = 7;
  localparam int SEC_FLAG_BIT = 7;
  // oscillator timing
  localparam int OSC_HZ          = 32768;
  localparam int SAMPLE_WIN_US   = 62500;
  // product stays below the int limit; dividing first would truncate the window to zero
  localparam int SAMPLE_WIN_OSC  = OSC_HZ * SAMPLE_WIN_US / 1000000;
  localparam int DIV_W           = 15;
endpackage

/* rtc_bcd_fix.sv */
`timescale 1ns/10ps
// combinational validity check and month-end correction of written data
module rtc_bcd_fix (
  // written fields
  input  wire logic [7:0] yearIn,
  input  wire logic [7:0] monthIn,
  input  wire logic [7:0] dateIn,
  input  wire logic [2:0] dowIn,
  input  wire logic [7:0] hourIn,
  input  wire logic [7:0] minIn,
  input  wire logic       mode24,
  // corrected fields
  output logic      [7:0] yearOut,
  output logic      [7:0] monthOut,
  output logic      [7:0] dateOut,
  output logic      [2:0] dowOut,
  output logic      [7:0] hourOut,
  output logic      [7:0] minOut
);
  function automatic logic nibOk(input logic [7:0] v);
    return (v[7:4] <= rtc_chk_pkg::BCD_MAX) && (v[3:0] <= rtc_chk_pkg::BCD_MAX);
  endfunction

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    return (v[3:0] == rtc_chk_pkg::BCD_MAX) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  logic [7:0] yv;
  logic [7:0] mv;
  logic [7:0] dv;
  logic [7:0] hb;
  logic [7:0] lastDay;
  logic       leap;

  always_comb begin
    yv = nibOk(yearIn) ? yearIn : rtc_chk_pkg::YEAR_DEF;
    mv = (nibOk(monthIn) && monthIn != 8'h00 && monthIn <= rtc_chk_pkg::MONTH_MAX)
         ? monthIn : rtc_chk_pkg::MONTH_DEF;
    dv = (nibOk(dateIn) && dateIn != rtc_chk_pkg::DATE_ZERO && dateIn <= rtc_chk_pkg::DATE_MAX)
         ? dateIn : rtc_chk_pkg::DATE_DEF;
    dowOut = (dowIn == rtc_chk_pkg::DOW_ZERO) ? rtc_chk_pkg::DOW_DEF : dowIn;
    minOut = (nibOk(minIn) && minIn <= rtc_chk_pkg::MIN_MAX) ? minIn : rtc_chk_pkg::MIN_DEF;
    // meridiem bit is kept only in 12-hour mode
    hb = {1'b0, hourIn[6:0]};
    if (mode24) begin
      hourOut = (nibOk(hb) && hb <= rtc_chk_pkg::HOUR24_MAX) ? hb : rtc_chk_pkg::HOUR_DEF;
    end else begin
      hourOut = (nibOk(hb) && hb <= rtc_chk_pkg::HOUR12_MAX) ? hourIn : rtc_chk_pkg::HOUR_DEF;
    end
    // year divisible by four in bcd: tens even with units 0,4,8 or tens odd with 2,6
    leap = yv[4] ? (yv[3:0] == 4'h2 || yv[3:0] == 4'h6)
                 : (yv[3:0] == 4'h0 || yv[3:0] == 4'h4 || yv[3:0] == 4'h8);
    unique case (mv)
      rtc_chk_pkg::MONTH_FEB: lastDay = leap ? rtc_chk_pkg::DAYS_29 : rtc_chk_pkg::DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = rtc_chk_pkg::DAYS_30;
      default: lastDay = rtc_chk_pkg::DAYS_31;
    endcase
    // substitution above feeds this correction, never the reverse
    yearOut  = yv;
    monthOut = mv;
    dateOut  = dv;
    if (dv > lastDay) begin
      dateOut = rtc_chk_pkg::DATE_DEF;
      if (mv == rtc_chk_pkg::MONTH_DEC) begin
        monthOut = rtc_chk_pkg::MONTH_DEF;
        yearOut  = (yv == 8'h99) ? rtc_chk_pkg::YEAR_DEF : bcdInc(yv);
      end else begin
        monthOut = bcdInc(mv);
      end
    end
  end
endmodule // rtc_bcd_fix

/* rtc_sync2.sv */
`timescale 1ns/10ps
// two-flop synchroniser for a group of pin levels
module rtc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else if (ce) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // rtc_sync2

/* rtc_write_check.sv */
`timescale 1ns/10ps
// write validity check, seconds fix-up and supply-low detector of the clock
module rtc_write_check (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // pins from outside the domain
  input  wire logic       oscClk,
  input  wire logic       chipSel,
  input  wire logic       supplyLow,
  // command decoder side, same clock
  input  wire logic       initCmd,
  input  wire logic       readCmd,
  input  wire logic       writeDone,
  input  wire logic       mode24,
  // written data
  input  wire logic [7:0] wrYear,
  input  wire logic [7:0] wrMonth,
  input  wire logic [7:0] wrDate,
  input  wire logic [2:0] wrDow,
  input  wire logic [7:0] wrHour,
  input  wire logic [7:0] wrMin,
  input  wire logic [7:0] wrSec,
  // counters
  output logic      [7:0] year_r,
  output logic      [7:0] month_r,
  output logic      [7:0] date_r,
  output logic      [2:0] dow_r,
  output logic      [7:0] hour_r,
  output logic      [7:0] min_r,
  output logic      [7:0] sec_r,
  // read image, detector and carries
  output logic      [7:0] rdHour_r,
  output logic      [7:0] rdSec_r,
  output logic            supply_low_flag_r,
  output logic            sampleWin_r,
  output logic            secCarry_r,
  output logic            minCarry_r
);
  typedef enum logic [2:0] {
    DET_RUN  = 3'b001,
    DET_HOLD = 3'b010,
    DET_READ = 3'b100
  } det_t;

  logic       oscS;
  logic       csS;
  logic       lowS;
  logic       oscD_r;
  logic       csD_r;
  logic       oscRise;
  logic       csRise;
  logic       csFall;
  logic [rtc_chk_pkg::DIV_W-1:0] div_r;
  logic       divRun_r;
  logic       secTick;
  logic       readPend_r;
  det_t       det_r;
  det_t       det_nxt;
  logic [7:0] fixYear;
  logic [7:0] fixMonth;
  logic [7:0] fixDate;
  logic [2:0] fixDow;
  logic [7:0] fixHour;
  logic [7:0] fixMin;

  localparam logic [rtc_chk_pkg::DIV_W-1:0] DIV_LAST = '1;
  localparam logic [rtc_chk_pkg::DIV_W-1:0] WIN_LAST =
    rtc_chk_pkg::DIV_W'(rtc_chk_pkg::SAMPLE_WIN_OSC - 1);

  function automatic logic secBad(input logic [7:0] v);
    return (v[3:0] > rtc_chk_pkg::BCD_MAX) || (v[6:0] > rtc_chk_pkg::SEC_MAX[6:0]);
  endfunction

  rtc_sync2 #(.W(3)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .din  ({oscClk, chipSel, supplyLow}),
    .dout ({oscS, csS, lowS})
  );

  rtc_bcd_fix u_fix (
    .yearIn   (wrYear),
    .monthIn  (wrMonth),
    .dateIn   (wrDate),
    .dowIn    (wrDow),
    .hourIn   (wrHour),
    .minIn    (wrMin),
    .mode24   (mode24),
    .yearOut  (fixYear),
    .monthOut (fixMonth),
    .dateOut  (fixDate),
    .dowOut   (fixDow),
    .hourOut  (fixHour),
    .minOut   (fixMin)
  );

  assign oscRise = oscS & ~oscD_r;
  assign csRise  = csS & ~csD_r;
  assign csFall  = ~csS & csD_r;
  assign secTick = oscRise & divRun_r & (div_r == DIV_LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscD_r <= 1'b0;
      csD_r  <= 1'b0;
    end else if (ce) begin
      oscD_r <= oscS;
      csD_r  <= csS;
    end
  end

  // divider halts during a write and restarts at chip select falling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r    <= '0;
      divRun_r <= 1'b0;
    end else if (ce) begin
      if (initCmd || writeDone) begin
        div_r    <= '0;
        divRun_r <= 1'b0;
      end else if (csFall) begin
        divRun_r <= 1'b1;
      end else if (oscRise && divRun_r) begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // counters load corrected data; seconds are not checked here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      year_r     <= rtc_chk_pkg::YEAR_DEF;
      month_r    <= rtc_chk_pkg::MONTH_DEF;
      date_r     <= rtc_chk_pkg::DATE_DEF;
      dow_r      <= rtc_chk_pkg::DOW_DEF;
      hour_r     <= rtc_chk_pkg::HOUR_DEF;
      min_r      <= rtc_chk_pkg::MIN_DEF;
      sec_r      <= rtc_chk_pkg::SEC_DEF;
      secCarry_r <= 1'b0;
      minCarry_r <= 1'b0;
    end else if (ce) begin
      secCarry_r <= secTick;
      minCarry_r <= 1'b0;
      if (initCmd) begin
        year_r  <= rtc_chk_pkg::YEAR_DEF;
        month_r <= rtc_chk_pkg::MONTH_DEF;
        date_r  <= rtc_chk_pkg::DATE_DEF;
        dow_r   <= rtc_chk_pkg::DOW_DEF;
        hour_r  <= rtc_chk_pkg::HOUR_DEF;
        min_r   <= rtc_chk_pkg::MIN_DEF;
        sec_r   <= rtc_chk_pkg::SEC_DEF;
      end else if (writeDone) begin
        year_r  <= fixYear;
        month_r <= fixMonth;
        date_r  <= fixDate;
        dow_r   <= fixDow;
        hour_r  <= fixHour;
        min_r   <= fixMin;
        sec_r   <= wrSec;
      end else if (secTick && secBad(sec_r)) begin
        // bad seconds fold to zero with a minute carry
        sec_r      <= rtc_chk_pkg::SEC_DEF;
        minCarry_r <= 1'b1;
      end
    end
  end

  // detector state: run samples, hold after a trip, read re-arms at cs fall
  always_comb begin
    det_nxt = det_r;
    unique case (det_r)
      DET_RUN: begin
        if (sampleWin_r && lowS) det_nxt = DET_HOLD;
      end
      DET_HOLD: begin
        if (readPend_r) det_nxt = DET_READ;
      end
      DET_READ: begin
        if (csFall) det_nxt = DET_RUN;
      end
      default: det_nxt = DET_RUN;
    endcase
    if (initCmd) det_nxt = DET_RUN;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      det_r <= DET_RUN;
    end else if (ce) begin
      det_r <= det_nxt;
    end
  end

  // window opens at start of each second on the divider while the detector is in DET_RUN
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampleWin_r <= 1'b0;
    end else if (ce) begin
      sampleWin_r <= divRun_r && (det_r == DET_RUN) && (div_r <= WIN_LAST);
    end
  end

  // flag set wins over the clear by a read-run window with good supply
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      supply_low_flag_r <= 1'b0;
    end else if (ce) begin
      if (initCmd) begin
        supply_low_flag_r <= 1'b0;
      end else if (sampleWin_r && lowS) begin
        supply_low_flag_r <= 1'b1;
      // clear only while running: the window lags a trip by one cycle
      end else if (sampleWin_r && !lowS && (det_r == DET_RUN)) begin
        supply_low_flag_r <= 1'b0;
      end
    end
  end

  // read after cs rise copies the flag into the seconds image
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readPend_r <= 1'b0;
      rdSec_r    <= 8'h00;
      rdHour_r   <= 8'h00;
    end else if (ce) begin
      if (csRise) begin
        readPend_r <= 1'b0;
      end else if (readCmd) begin
        readPend_r <= 1'b1;
      end else if (csFall) begin
        readPend_r <= 1'b0;
      end
      if (readCmd) begin
        rdSec_r <= {supply_low_flag_r, sec_r[6:0]};
        rdHour_r <= mode24
          ? {(hour_r[6:0] > rtc_chk_pkg::HOUR12_MAX[6:0]), hour_r[6:0]}
          : hour_r;
      end
    end
  end

  a_bad_sec_fold: assert property (@(posedge mclk) disable iff (rst)
    (ce && secTick && !writeDone && !initCmd && secBad(sec_r))
      |=> (sec_r == rtc_chk_pkg::SEC_DEF) && minCarry_r)
    else $error("bad seconds not folded at carry");
  a_trip_latch: assert property (@(posedge mclk) disable iff (rst)
    (ce && sampleWin_r && lowS && !initCmd) |=> supply_low_flag_r && (det_r == DET_HOLD))
    else $error("low sample did not latch");
  a_hold_no_win: assert property (@(posedge mclk) disable iff (rst)
    (det_r == DET_HOLD) |-> ##1 !sampleWin_r)
    else $error("sampling while held");
  a_read_image: assert property (@(posedge mclk) disable iff (rst)
    (ce && readCmd) |=> rdSec_r[rtc_chk_pkg::SEC_FLAG_BIT] == $past(supply_low_flag_r))
    else $error("flag missing from seconds image");
  a_rearm_fall: assert property (@(posedge mclk) disable iff (rst)
    (ce && det_r == DET_READ && csFall && !initCmd) |=> det_r == DET_RUN)
    else $error("cs fall did not re-arm");
  a_mer_read: assert property (@(posedge mclk) disable iff (rst)
    (ce && readCmd && mode24) |=> rdHour_r[rtc_chk_pkg::HOUR_MER_BIT]
      == ($past(hour_r[6:0]) > rtc_chk_pkg::HOUR12_MAX[6:0]))
    else $error("meridiem wrong in 24-hour read");
  a_write_load: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd) |=> (date_r >= rtc_chk_pkg::DATE_DEF)
      && (date_r <= rtc_chk_pkg::DATE_MAX) && (date_r[3:0] <= rtc_chk_pkg::BCD_MAX)
      && (min_r <= rtc_chk_pkg::MIN_MAX) && (min_r[3:0] <= rtc_chk_pkg::BCD_MAX))
    else $error("corrected data not loaded");
  a_div_halt: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone) |=> !divRun_r ##1 !sampleWin_r)
    else $error("divider runs after write");

  // write path: every loaded field but the raw seconds lies inside its legal range; a 12-hour read returns the hour unchanged
  a_dow_valid: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd) |=> (dow_r != rtc_chk_pkg::DOW_ZERO))
    else $error("day-of-week zero after write");
  a_year_bcd: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd) |=> (year_r[7:4] <= rtc_chk_pkg::BCD_MAX)
      && (year_r[3:0] <= rtc_chk_pkg::BCD_MAX))
    else $error("year not bcd after write");
  a_month_range: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd) |=> (month_r >= rtc_chk_pkg::MONTH_DEF)
      && (month_r <= rtc_chk_pkg::MONTH_MAX) && (month_r[3:0] <= rtc_chk_pkg::BCD_MAX))
    else $error("month out of range after write");
  a_hour24_range: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd && mode24) |=> (hour_r <= rtc_chk_pkg::HOUR24_MAX)
      && (hour_r[3:0] <= rtc_chk_pkg::BCD_MAX))
    else $error("24-hour value out of range");
  a_hour12_range: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd && !mode24) |=> (hour_r[6:0] <= rtc_chk_pkg::HOUR12_MAX[6:0])
      && (hour_r[3:0] <= rtc_chk_pkg::BCD_MAX))
    else $error("12-hour value out of range");
  a_sec_raw: assert property (@(posedge mclk) disable iff (rst)
    (ce && writeDone && !initCmd) |=> (sec_r == $past(wrSec)))
    else $error("seconds altered at write");
  a_hour12_read: assert property (@(posedge mclk) disable iff (rst)
    (ce && readCmd && !mode24) |=> (rdHour_r == $past(hour_r)))
    else $error("12-hour read changed the hour");

  // detector: sampling only inside the window of a running divider
  a_win_stop: assert property (@(posedge mclk) disable iff (rst)
    (ce && !divRun_r) |=> !sampleWin_r)
    else $error("window open with divider stopped");
  a_win_bound: assert property (@(posedge mclk) disable iff (rst)
    (ce && (div_r > WIN_LAST)) |=> !sampleWin_r)
    else $error("window longer than its span");
  a_flag_hold: assert property (@(posedge mclk) disable iff (rst)
    (ce && supply_low_flag_r && (det_r != DET_RUN) && !initCmd) |=> supply_low_flag_r)
    else $error("held flag dropped");
  a_hold_read: assert property (@(posedge mclk) disable iff (rst)
    (ce && (det_r == DET_HOLD) && readPend_r && !initCmd) |=> (det_r == DET_READ))
    else $error("read did not release the hold");
  a_init_clear: assert property (@(posedge mclk) disable iff (rst)
    (ce && initCmd) |=> !supply_low_flag_r && (det_r == DET_RUN) && !divRun_r)
    else $error("initialization left detector state");

  // carries: one-cycle pulses, the minute carry only beside a second carry
  a_carry_pulse: assert property (@(posedge mclk) disable iff (rst)
    (ce && secCarry_r) |=> !secCarry_r)
    else $error("second carry longer than a cycle");
  a_min_carry: assert property (@(posedge mclk) disable iff (rst)
    minCarry_r |-> secCarry_r && (sec_r == rtc_chk_pkg::SEC_DEF))
    else $error("minute carry without folded seconds");
endmodule // rtc_write_check

/* rtc_host_model.sv */
`timescale 1ns/10ps
// host processor and crystal model on the far side of the write check block
module rtc_host_model (
  // clock
  input  wire logic       mclk,
  // pins
  output logic            oscClk,
  output logic            chipSel,
  // decoded commands
  output logic            initCmd,
  output logic            readCmd,
  output logic            writeDone,
  output logic            mode24,
  // written data
  output logic      [7:0] wrYear,
  output logic      [7:0] wrMonth,
  output logic      [7:0] wrDate,
  output logic      [2:0] wrDow,
  output logic      [7:0] wrHour,
  output logic      [7:0] wrMin,
  output logic      [7:0] wrSec
);
  // crystal runs free, each edge 2 ns before an mclk rise
  initial begin
    {chipSel, initCmd, readCmd, writeDone, mode24} = 5'h00;
    {wrYear, wrMonth, wrDate, wrDow, wrHour, wrMin, wrSec} = 51'h0;
    oscClk = 1'b0;
    #3;
    forever #80 oscClk = ~oscClk;
  end
  // pins pass a synchroniser, so the command waits a few cycles
  task automatic frameStart(input logic m);
    @(posedge mclk);
    chipSel <= 1'b1;
    mode24  <= m;
    repeat (4) @(posedge mclk);
  endtask
  task automatic frameEnd();
    @(posedge mclk);
    chipSel <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // meridiem bit of h is given as 0 or 1 in 12-hour mode
  task automatic doWrite(input logic m, input logic [2:0] w,
                         input logic [7:0] y, mo, d, h, mi, s);
    frameStart(m);
    writeDone <= 1'b1;
    wrYear    <= y;
    wrMonth   <= mo;
    wrDate    <= d;
    wrDow     <= w;
    wrHour    <= h;
    wrMin     <= mi;
    wrSec     <= s;
    @(posedge mclk);
    writeDone <= 1'b0;
    // stale data lines show the inverse, never the last value
    {wrYear, wrMonth, wrDate, wrDow, wrHour, wrMin, wrSec} <= ~{y, mo, d, w, h, mi, s};
    frameEnd();
  endtask
  task automatic doRead();
    frameStart(mode24);
    readCmd <= 1'b1;
    @(posedge mclk);
    readCmd <= 1'b0;
    frameEnd();
  endtask
  task automatic doInit();
    @(posedge mclk);
    initCmd <= 1'b1;
    @(posedge mclk);
    initCmd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule // rtc_host_model

/* rtc_write_check_tb_top.sv */
`timescale 1ns/10ps
// self-checking bench for the write check and supply-low detector
module rtc_write_check_tb_top;
  typedef struct packed {
    logic       m;
    logic [2:0] w;
    logic [7:0] y, mo, d, h, mi, ey, emo, ed, eh, emi, erh;
  } row_t;
  // mode, dow, written y mo d h mi, then expected y mo d h mi and read hour
  localparam row_t ROWS [11] = '{
    {1'h1, 3'h7, 8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'ha3},
    {1'h1, 3'h0, 8'h1a, 8'h00, 8'h00, 8'h24, 8'h60, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00},
    {1'h1, 3'h5, 8'ha5, 8'h13, 8'h32, 8'h30, 8'h7f, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00},
    {1'h1, 3'h1, 8'h24, 8'h02, 8'h29, 8'h85, 8'h00, 8'h24, 8'h02, 8'h29, 8'h05, 8'h00, 8'h05},
    {1'h1, 3'h1, 8'h23, 8'h02, 8'h29, 8'h12, 8'h00, 8'h23, 8'h03, 8'h01, 8'h12, 8'h00, 8'h92},
    {1'h1, 3'h1, 8'h00, 8'h04, 8'h31, 8'h11, 8'h00, 8'h00, 8'h05, 8'h01, 8'h11, 8'h00, 8'h11},
    {1'h1, 3'h1, 8'h00, 8'h1f, 8'h3a, 8'h2a, 8'h5a, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00},
    {1'h0, 3'h2, 8'h00, 8'h01, 8'h15, 8'h91, 8'h00, 8'h00, 8'h01, 8'h15, 8'h91, 8'h00, 8'h91},
    {1'h0, 3'h2, 8'h00, 8'h01, 8'h15, 8'h12, 8'h00, 8'h00, 8'h01, 8'h15, 8'h00, 8'h00, 8'h00},
    {1'h1, 3'h4, 8'h24, 8'h02, 8'h30, 8'h00, 8'h00, 8'h24, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00},
    {1'h1, 3'h4, 8'h9a, 8'h02, 8'h29, 8'h00, 8'h00, 8'h00, 8'h02, 8'h29, 8'h00, 8'h00, 8'h00}
  };
  logic       mclk, rst, ce, supplyLow;
  logic       oscClk, chipSel, initCmd, readCmd, writeDone, mode24;
  logic [7:0] wrYear, wrMonth, wrDate, wrHour, wrMin, wrSec;
  logic [2:0] wrDow, dow_r;
  logic [7:0] year_r, month_r, date_r, hour_r, min_r, sec_r, rdHour_r, rdSec_r;
  logic       supply_low_flag_r, sampleWin_r, secCarry_r, minCarry_r;
  int         fail_count = 0;
  int         n_tests    = 0;
  int         cycles     = 0;
  int         winLen     = 0;

  rtc_host_model host (.mclk, .oscClk, .chipSel, .initCmd, .readCmd, .writeDone, .mode24,
    .wrYear, .wrMonth, .wrDate, .wrDow, .wrHour, .wrMin, .wrSec);
  rtc_write_check DUT (.mclk, .rst, .ce, .oscClk, .chipSel, .supplyLow, .initCmd,
    .readCmd, .writeDone, .mode24, .wrYear, .wrMonth, .wrDate, .wrDow, .wrHour, .wrMin,
    .wrSec, .year_r, .month_r, .date_r, .dow_r, .hour_r, .min_r, .sec_r, .rdHour_r,
    .rdSec_r, .supply_low_flag_r, .sampleWin_r, .secCarry_r, .minCarry_r);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cmpByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpBit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait on the window (sel 1) or the flag (sel 0)
  task automatic waitLevel(input logic sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((sel ? sampleWin_r : supply_low_flag_r) === v) break;
      @(posedge mclk);
    end
  endtask

  // window length counted since the last write restarted the divider
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (writeDone === 1'b1) begin
      winLen <= 0;
    end else if (sampleWin_r === 1'b1) begin
      winLen <= winLen + 1;
    end
    if (cycles == 90000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    row_t r;
    rst       = 1'b1;
    ce        = 1'b1;
    supplyLow = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    cmpByte("reset month", 8'h01, month_r);
    cmpByte("reset dow", 8'h01, {5'h00, dow_r});
    cmpBit("reset flag", 1'b0, supply_low_flag_r);
    $display("test reset done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      host.doWrite(r.m, r.w, r.y, r.mo, r.d, r.h, r.mi, 8'h00);
      cmpByte("year", r.ey, year_r);
      cmpByte("month", r.emo, month_r);
      cmpByte("date", r.ed, date_r);
      cmpByte("dow", {5'h00, (r.w == 3'h0) ? 3'h1 : r.w}, {5'h00, dow_r});
      cmpByte("hour", r.eh, hour_r);
      cmpByte("minute", r.emi, min_r);
      cmpByte("seconds", 8'h00, sec_r);
      host.doRead();
      cmpByte("read hour", r.erh, rdHour_r);
      $display("test row %0d done", i);
    end
    // first full window after the last row's write, supply good
    waitLevel(1'b1, 1'b0, 40000);
    cmpBit("window length", 1'b1, winLen > 32704 && winLen < 32832);
    cmpBit("flag stays clear", 1'b0, supply_low_flag_r);
    // rewrite restarts the divider; bad seconds pass unchecked
    host.doWrite(1'b1, 3'h3, 8'h24, 8'h12, 8'h31, 8'h10, 8'h30, 8'h7a);
    cmpByte("raw seconds", 8'h7a, sec_r);
    // trip inside the window, hold, report, release
    waitLevel(1'b1, 1'b1, 100);
    cmpBit("window open", 1'b1, sampleWin_r);
    supplyLow <= 1'b1;
    waitLevel(1'b0, 1'b1, 100);
    cmpBit("flag trip", 1'b1, supply_low_flag_r);
    supplyLow <= 1'b0;
    repeat (50) @(posedge mclk);
    cmpBit("flag held", 1'b1, supply_low_flag_r);
    host.doRead();
    cmpBit("read flag set", 1'b1, rdSec_r[7]);
    cmpByte("read seconds", 8'hfa, rdSec_r);
    waitLevel(1'b0, 1'b0, 200);
    cmpBit("flag cleared", 1'b0, supply_low_flag_r);
    host.doRead();
    cmpBit("read flag clear", 1'b0, rdSec_r[7]);
    $display("test detector done");
    // trip again, then the hold must outlive the window
    supplyLow <= 1'b1;
    waitLevel(1'b0, 1'b1, 100);
    supplyLow <= 1'b0;
    repeat (33000) @(posedge mclk);
    cmpBit("held past window", 1'b1, supply_low_flag_r);
    cmpBit("no window in hold", 1'b0, sampleWin_r);
    cmpByte("seconds before carry", 8'h7a, sec_r);
    cmpBit("no early carry", 1'b0, minCarry_r);
    // a frozen block ignores the initialization
    ce <= 1'b0;
    host.doInit();
    cmpBit("frozen flag", 1'b1, supply_low_flag_r);
    ce <= 1'b1;
    host.doInit();
    cmpBit("init flag", 1'b0, supply_low_flag_r);
    cmpByte("init month", 8'h01, month_r);
    cmpByte("init date", 8'h01, date_r);
    $display("test window and init done");
    give_verdict();
  end
endmodule // rtc_write_check_tb_top
